// [i2c_slave_pkg.sv]
/*
  Shared constants and types for the two-wire slave port: mode codes, byte
  timing, reset values, the state enumeration and the state carriers.
  Assumes one core clock and one link clock taken from the serial clock pin.
*/
package i2c_slave_pkg;

  // Port mode field codes for the slave variants.
  localparam logic [3:0] MODE_SLAVE_7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE_10 = 4'h7;
  localparam logic [3:0] MODE_SLAVE_7_SP = 4'hE;
  localparam logic [3:0] MODE_SLAVE_10_SP = 4'hF;
  localparam int MODE_TEN_BIT_POS = 0;
  localparam int MODE_SP_IRQ_POS = 3;

  // Byte timing in serial clock pulses.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_PULSE = 4'h9;

  // High address byte pattern for ten-bit addressing.
  localparam logic [4:0] TEN_BIT_PATTERN = 5'h1E;

  // Reset values.
  localparam logic [7:0] OWN_ADDRESS_RST = 8'h00;
  localparam logic CLOCK_RELEASE_RST = 1'b1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ADDR_LO = 5'h04,
    ST_RX = 5'h08,
    ST_TX = 5'h10
  } slave_state_t;

  // Link domain state: sampled data bit and the edge toggle.
  typedef struct packed {
    logic cap_bit;
    logic tog;
  } link_state_t;

  // Core domain state.
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic tog_s1;
    logic tog_s2;
    logic tog_p;
    slave_state_t state;
    slave_state_t nxt;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic [7:0] own_addr;
    logic bf;
    logic ov;
    logic irq;
    logic ua;
    logic ua_hold;
    logic clock_release_bit;
    logic dir;
    logic ack;
    logic byte_ok;
    logic read_addr;
    logic addr_byte;
    logic lo_ok;
    logic nack;
    logic scl_hold;
  } core_state_t;

endpackage : i2c_slave_pkg

// [i2c_slave_addr_stretch.sv]
/*
  Slave side of the two-wire serial port: address matching in 7-bit and
  10-bit modes, byte receive and transmit, acknowledge, flag timing and
  clock stretching. Firmware controls arrive as plain ports on mclk_in.
  Assumes the serial clock pin also feeds scl_link_clk_in as a clock and
  that the surrounding pad logic resolves the open-drain wires.
*/
// Contract
// - After START, shift eight bits in, each sampled on rising serial clock.
// - Compare shift bits 7:1 with own address at eighth falling edge.
// - On match without overflow: buffer load, buffer full, ACK, flag at ninth fall.
// - No ACK when buffer full or receive overflow is already set.
// - After high byte set flag, full, update; address write releases clock.
// - After low byte set the three flags; restoring high address releases clock.
// - Ten-bit read after repeated START sets flag and full, not update.
// - Matched write address clears direction, loads buffer, drives ACK low.
// - Interrupt flag set once per byte, held until software clears it.
// - With stretch enable, hold clock after each received byte until release.
// - Matched read address sets direction, loads buffer, ACKs, always stretches.
// - Buffer write loads shifter; after release shift out on falling edges.
// - Latch master ACK on ninth rise; NACK resets status, waits for START.
// - Transmit sets interrupt flag at ninth falling edge of each byte; the code skips it after a master NACK.
// - Seven-bit receive with stretch: buffer full at ninth fall clears release.
// - Buffer read before ninth fall leaves release set, no stretch.
// - Software may set release regardless of buffer full.
// - Ten-bit address bytes stretch on update flag, release on address write.
// - Transmit clears release after ninth fall if buffer empty.
// - Ten-bit transmit: third address byte leaves update clear, full governs.
// - Drive clock low only once sampled low; hold until release and line free.
// - Mode 6 is 7-bit, 7 is 10-bit; 14 and 15 add START/STOP flags.
// - Set overflow when byte arrives with buffer still full; software clears.
// - Without stretch enable only transmit stretches; the code also stretches ten-bit address bytes on update.
`timescale 1ns/1ps
module i2c_slave_addr_stretch
  import i2c_slave_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic scl_link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic port_enable_in,
  input wire logic [3:0] port_mode_in,
  input wire logic stretch_enable_in,
  input wire logic own_address_wr_in,
  input wire logic [7:0] own_address_data_in,
  input wire logic buffer_wr_in,
  input wire logic [7:0] buffer_data_in,
  input wire logic buffer_rd_in,
  input wire logic clock_release_set_in,
  input wire logic overflow_clr_in,
  input wire logic irq_clr_in,
  output logic [7:0] holding_buffer_out,
  output logic [7:0] own_address_out,
  output logic buffer_full_out,
  output logic receive_overflow_out,
  output logic port_interrupt_out,
  output logic address_update_out,
  output logic clock_release_out,
  output logic direction_out
);

  link_state_t lk_q;
  core_state_t st_q;
  core_state_t st_d;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic ten_bit;
  logic overflow;
  logic match7;
  logic match_lo;
  logic want_hold;

  // Link domain: sample SDA on every rising serial clock and flip a toggle.
  // The clock stops between frames, so only the toggle and the sampled bit
  // cross; the bit stays stable until the next rising edge.
  always_ff @(posedge scl_link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lk_q <= '0;
    end else begin
      lk_q.cap_bit <= sda_in;
      lk_q.tog <= ~lk_q.tog;
    end
  end

  // Events seen from the second synchroniser stage and the copy after it.
  assign rise_ev = st_q.tog_s2 ^ st_q.tog_p;
  assign fall_ev = st_q.scl_p & ~st_q.scl_s2;
  assign start_ev = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
  assign stop_ev = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
  assign ten_bit = port_mode_in[MODE_TEN_BIT_POS];
  assign overflow = st_q.bf | st_q.ov;
  assign match7 = (st_q.shift[7:1] == st_q.own_addr[7:1]);
  assign match_lo = (st_q.shift == st_q.own_addr);
  // Clock is held for a cleared release bit or a pending address update.
  assign want_hold = ~st_q.clock_release_bit | st_q.ua_hold;

  // Next-state logic for the whole core domain.
  always_comb begin
    st_d = st_q;
    st_d.scl_s1 = scl_in;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_p = st_q.scl_s2;
    st_d.sda_s1 = sda_in;
    st_d.sda_s2 = st_q.sda_s1;
    st_d.sda_p = st_q.sda_s2;
    st_d.tog_s1 = lk_q.tog;
    st_d.tog_s2 = st_q.tog_s1;
    st_d.tog_p = st_q.tog_s2;

    if (!port_enable_in) begin
      st_d.state = ST_IDLE;
      st_d.cnt = 4'h0;
      st_d.ack = 1'b0;
      st_d.lo_ok = 1'b0;
    end else if (start_ev) begin
      // A repeated START keeps the ten-bit low match for a following read.
      st_d.state = ST_ADDR;
      st_d.cnt = 4'h0;
      st_d.ack = 1'b0;
      if (port_mode_in[MODE_SP_IRQ_POS]) begin
        st_d.irq = 1'b1;
      end
    end else if (stop_ev) begin
      st_d.state = ST_IDLE;
      st_d.cnt = 4'h0;
      st_d.ack = 1'b0;
      st_d.lo_ok = 1'b0;
      if (port_mode_in[MODE_SP_IRQ_POS]) begin
        st_d.irq = 1'b1;
      end
    end else if (rise_ev && st_q.state != ST_IDLE) begin
      if (st_q.cnt < BITS_PER_BYTE && st_q.state != ST_TX) begin
        st_d.shift = {st_q.shift[6:0], lk_q.cap_bit};
      end
      if (st_q.cnt == BITS_PER_BYTE && st_q.state == ST_TX) begin
        st_d.nack = lk_q.cap_bit;
      end
      if (st_q.cnt < ACK_PULSE) begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
    end else if (fall_ev && st_q.state != ST_IDLE) begin
      if (st_q.state == ST_TX) begin
        if (st_q.cnt != 4'h0 && st_q.cnt < BITS_PER_BYTE) begin
          st_d.shift = {st_q.shift[6:0], 1'b0};
        end else if (st_q.cnt == BITS_PER_BYTE) begin
          st_d.bf = 1'b0; // Byte fully sent, buffer is free again.
          st_d.byte_ok = 1'b1;
        end else if (st_q.cnt == ACK_PULSE) begin
          st_d.cnt = 4'h0;
          if (st_q.nack) begin
            st_d.state = ST_IDLE;
            st_d.dir = 1'b0;
            st_d.ua = 1'b0;
            st_d.lo_ok = 1'b0;
          end else begin
            st_d.irq = 1'b1;
            if (!st_q.bf) begin
              st_d.clock_release_bit = 1'b0;
            end
          end
          st_d.byte_ok = 1'b0;
        end
      end else if (st_q.cnt == BITS_PER_BYTE) begin
        // Eighth falling edge: decide the byte and the acknowledge.
        st_d.byte_ok = 1'b0;
        st_d.read_addr = 1'b0;
        st_d.addr_byte = 1'b0;
        st_d.nxt = ST_IDLE;
        if (st_q.state == ST_RX) begin
          st_d.nxt = ST_RX;
          st_d.byte_ok = 1'b1;
        end else if (st_q.state == ST_ADDR_LO) begin
          if (match_lo) begin
            st_d.nxt = ST_RX;
            st_d.byte_ok = 1'b1;
            st_d.addr_byte = 1'b1;
            st_d.lo_ok = 1'b1;
          end
        end else if (!ten_bit) begin
          if (match7) begin
            st_d.nxt = st_q.shift[0] ? ST_TX : ST_RX;
            st_d.byte_ok = 1'b1;
            st_d.read_addr = st_q.shift[0];
            st_d.addr_byte = 1'b1;
          end
        end else if (match7 && st_q.shift[7:3] == TEN_BIT_PATTERN) begin
          st_d.byte_ok = 1'b1;
          st_d.addr_byte = 1'b1;
          if (st_q.shift[0] && st_q.lo_ok) begin
            st_d.nxt = ST_TX;
            st_d.read_addr = 1'b1;
          end else if (!st_q.shift[0]) begin
            st_d.nxt = ST_ADDR_LO;
          end else begin
            st_d.byte_ok = 1'b0;
          end
        end
        if (st_d.byte_ok) begin
          if (overflow) begin
            st_d.ov = 1'b1;
            st_d.ack = 1'b0;
          end else begin
            st_d.buffer = st_q.shift;
            st_d.bf = 1'b1;
            st_d.ack = 1'b1;
            // The low ten-bit address byte carries address bits, not a direction.
            if (st_d.addr_byte && st_q.state != ST_ADDR_LO) begin
              st_d.dir = st_q.shift[0];
            end
            if (st_d.addr_byte && ten_bit && !st_d.read_addr) begin
              st_d.ua = 1'b1;
            end
          end
        end
      end else if (st_q.cnt == ACK_PULSE) begin
        // Ninth falling edge: end the acknowledge, raise the flag, stretch.
        st_d.ack = 1'b0;
        st_d.cnt = 4'h0;
        st_d.state = st_q.nxt;
        if (st_q.byte_ok) begin
          st_d.irq = 1'b1;
          if (st_q.read_addr) begin
            st_d.clock_release_bit = 1'b0;
          end else if (st_q.addr_byte && ten_bit) begin
            st_d.ua_hold = st_q.ua;
          end else if (!st_q.addr_byte && stretch_enable_in && st_q.bf) begin
            st_d.clock_release_bit = 1'b0;
          end
        end
        st_d.byte_ok = 1'b0;
      end
    end

    // Firmware side effects; a hardware set in the same cycle wins, except for the update flag.
    // An address write clears the update flag even in the cycle that sets it,
    // so a write racing the eighth edge cancels the address stretch.
    if (own_address_wr_in) begin
      st_d.own_addr = own_address_data_in;
      st_d.ua = 1'b0;
      st_d.ua_hold = 1'b0;
    end
    if (buffer_rd_in && !(st_d.bf && !st_q.bf)) begin
      st_d.bf = 1'b0;
    end
    if (buffer_wr_in && st_q.state == ST_TX) begin
      st_d.buffer = buffer_data_in;
      st_d.shift = buffer_data_in;
      st_d.bf = 1'b1;
    end
    if (clock_release_set_in) begin
      st_d.clock_release_bit = 1'b1;
    end
    if (overflow_clr_in && !(st_d.ov && !st_q.ov)) begin
      st_d.ov = 1'b0;
    end
    if (irq_clr_in && !(st_d.irq && !st_q.irq)) begin
      st_d.irq = 1'b0;
    end

    // Pull the clock only after the line is already seen low.
    st_d.scl_hold = want_hold & port_enable_in & (st_q.scl_hold | ~st_q.scl_s2);
  end

  // One register bank for the core; the clock enable freezes it all.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '{state: ST_IDLE, nxt: ST_IDLE, own_addr: OWN_ADDRESS_RST,
                clock_release_bit: CLOCK_RELEASE_RST, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
                sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, default: '0};
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  // Open-drain outputs only ever pull low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = st_q.scl_hold;
  // In transmit the last bit stands until the eighth falling edge; letting go
  // on the eighth rise would move SDA while SCL is high and look like a STOP.
  assign sda_oe_out = st_q.ack |
                      (st_q.state == ST_TX && !st_q.shift[7] &&
                       (st_q.cnt < BITS_PER_BYTE ||
                        (st_q.cnt == BITS_PER_BYTE && !st_q.byte_ok)));
  assign holding_buffer_out = st_q.buffer;
  assign own_address_out = st_q.own_addr;
  assign buffer_full_out = st_q.bf;
  assign receive_overflow_out = st_q.ov;
  assign port_interrupt_out = st_q.irq;
  assign address_update_out = st_q.ua;
  assign clock_release_out = st_q.clock_release_bit;
  assign direction_out = st_q.dir;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  ack_no_ovf_a: assert property ($rose(st_q.ack) |-> $past(!st_q.bf && !st_q.ov))
    else $error("Acknowledge given while overflow held.");

  ack_loads_buf_a: assert property ($rose(st_q.ack) |-> st_q.bf && st_q.buffer == st_q.shift)
    else $error("Acknowledge without buffer load.");

  irq_ninth_a: assert property (clk_en_in && port_enable_in && fall_ev
                                && st_q.cnt == ACK_PULSE && st_q.byte_ok
                                && st_q.state != ST_TX && !irq_clr_in |=> st_q.irq)
    else $error("Byte completed without interrupt flag.");

  hold_low_first_a: assert property ($rose(st_q.scl_hold) |-> $past(!st_q.scl_s2))
    else $error("Clock pulled before it was seen low.");

  rx_stretch_a: assert property (clk_en_in && port_enable_in && fall_ev
                                 && st_q.cnt == ACK_PULSE
                                 && st_q.byte_ok && !st_q.addr_byte && stretch_enable_in
                                 && st_q.bf && !clock_release_set_in |=> !st_q.clock_release_bit)
    else $error("Full buffer did not stretch receive.");

  // Only the address byte itself stretches here; later transmit bytes follow the buffer.
  read_hold_a: assert property (clk_en_in && port_enable_in && fall_ev
                                && st_q.cnt == ACK_PULSE && st_q.state != ST_TX
                                && st_q.byte_ok && st_q.read_addr && !clock_release_set_in
                                |=> !st_q.clock_release_bit ##0 st_q.state == ST_TX)
    else $error("Read address did not stretch.");

  ua_clear_a: assert property (clk_en_in && own_address_wr_in |=> !st_q.ua && !st_q.ua_hold)
    else $error("Address write left update pending.");

  nack_idle_a: assert property (clk_en_in && port_enable_in && fall_ev && !start_ev
                                && st_q.state == ST_TX && st_q.cnt == ACK_PULSE && st_q.nack
                                |=> st_q.state == ST_IDLE && !st_q.dir)
    else $error("Master NACK did not end transmit.");

  tx_empty_stretch_a: assert property (clk_en_in && fall_ev && st_q.state == ST_TX
                                       && st_q.cnt == ACK_PULSE && !st_q.nack && !st_q.bf
                                       && !clock_release_set_in && !buffer_wr_in
                                       |=> !st_q.clock_release_bit)
    else $error("Empty transmit buffer did not stretch.");

  // A transmitted bit must not move while SCL is high, or the master sees START or STOP.
  tx_bit_stable_a: assert property (clk_en_in && port_enable_in && rise_ev
                                    && !start_ev && !stop_ev
                                    && st_q.state == ST_TX && !buffer_wr_in
                                    |=> $stable(sda_oe_out))
    else $error("Transmit data moved during the high clock phase.");

  // A START always reopens address reception from the first bit.
  start_addr_a: assert property (clk_en_in && port_enable_in && start_ev
                                 |=> st_q.state == ST_ADDR && st_q.cnt == 4'h0)
    else $error("START did not restart address reception.");

  // With release set and no address update pending the clock must be let go.
  release_free_a: assert property (clk_en_in && st_q.clock_release_bit && !st_q.ua_hold
                                   |=> !st_q.scl_hold)
    else $error("Clock held with release set.");

  // A data byte into a full buffer is refused and flagged as an overflow.
  ovf_refuse_a: assert property (clk_en_in && port_enable_in && fall_ev && st_q.bf
                                 && st_q.state == ST_RX && st_q.cnt == BITS_PER_BYTE
                                 |=> st_q.ov && !st_q.ack)
    else $error("Byte into a full buffer was not refused.");

  // The low ten-bit address byte must leave the direction bit alone.
  lo_dir_a: assert property (clk_en_in && port_enable_in && fall_ev
                             && st_q.state == ST_ADDR_LO && st_q.cnt == BITS_PER_BYTE
                             |=> $stable(st_q.dir))
    else $error("Low address byte changed the direction bit.");

endmodule : i2c_slave_addr_stretch

// [i2c_master_model.sv]
/*
  Behavioural two-wire bus master used as the far side of the slave port.
  Assumes the bench resolves the open-drain wires and feeds the levels back.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic mclk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  localparam int HALF = 8;
  int stuck = 0;
  // Both lines start released, so the pull-ups hold them high.
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  // One clock pulse. The wait for the clock is bounded so a stuck stretch cannot hang.
  task automatic bit_io(input logic b, output logic seen);
    int i;
    tick(HALF / 2);
    sda_low_out <= ~b;
    tick(HALF / 2);
    scl_low_out <= 1'b0;
    i = 0;
    tick(1);
    while (scl_in !== 1'b1 && i < 4000) begin
      tick(1);
      i++;
    end
    if (i >= 4000) stuck++;
    seen = sda_in;
    tick(HALF);
    scl_low_out <= 1'b1;
  endtask : bit_io
  // Eight bits MSB first, then the acknowledge pulse.
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
                           output logic acked);
    logic a;
    for (int k = 7; k >= 0; k--) bit_io(tx[k], rx[k]);
    bit_io(ack_bit, a);
    acked = ~a;
  endtask : xfer_byte
  // Data falls while the clock is high; also serves as a repeated start.
  task automatic start_cond();
    sda_low_out <= 1'b0;
    tick(HALF / 2);
    scl_low_out <= 1'b0;
    tick(HALF);
    sda_low_out <= 1'b1;
    tick(HALF);
    scl_low_out <= 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    sda_low_out <= 1'b1;
    tick(HALF / 2);
    scl_low_out <= 1'b0;
    tick(HALF);
    sda_low_out <= 1'b0;
    tick(HALF);
  endtask : stop_cond
endmodule : i2c_master_model

// [i2c_slave_addr_stretch_bench.sv]
/*
  Self-checking bench for the two-wire slave port, with a master model.
  Assumes the serial clock wire also clocks the link domain of the slave.
*/
`timescale 1ns/1ps
module i2c_slave_addr_stretch_bench;
  import i2c_slave_pkg::*;
  logic mclk_in, arst_n_in, clk_en_in, port_enable_in, stretch_enable_in, overflow_clr_in;
  logic own_address_wr_in, buffer_wr_in, buffer_rd_in, clock_release_set_in, irq_clr_in;
  logic [3:0] port_mode_in;
  logic [7:0] own_address_data_in, buffer_data_in, holding_buffer_out, own_address_out;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, buffer_full_out, receive_overflow_out;
  logic port_interrupt_out, address_update_out, clock_release_out, direction_out;
  logic m_scl, m_sda, acked;
  logic [7:0] rx, d, hi;
  logic [6:0] a;
  logic [31:0] seed;
  int err_count = 0;
  int check_count = 0;
  // Wired-and buses: any party pulling low wins over the pull-up.
  wire logic scl_w = ~(m_scl | scl_oe_out);
  wire logic sda_w = ~(m_sda | sda_oe_out);
  i2c_slave_addr_stretch u_i2c_slave_addr_stretch (
    .mclk_in, .arst_n_in, .clk_en_in, .scl_link_clk_in(scl_w), .scl_in(scl_w),
    .sda_in(sda_w), .scl_out, .scl_oe_out, .sda_out, .sda_oe_out, .port_enable_in,
    .port_mode_in, .stretch_enable_in, .own_address_wr_in, .own_address_data_in,
    .buffer_wr_in, .buffer_data_in, .buffer_rd_in, .clock_release_set_in, .overflow_clr_in,
    .irq_clr_in, .holding_buffer_out, .own_address_out, .buffer_full_out,
    .receive_overflow_out, .port_interrupt_out, .address_update_out, .clock_release_out,
    .direction_out
  );
  i2c_master_model u_i2c_master_model (
    .mclk_in, .scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl), .sda_low_out(m_sda)
  );
  // Core clock at 10 MHz.
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] addr7(input logic [6:0] ad, input logic rw);
    return {ad, rw};
  endfunction : addr7
  function automatic logic [7:0] ten_hi(input logic [1:0] top, input logic rw);
    return {TEN_BIT_PATTERN, top, rw};
  endfunction : ten_hi
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // One firmware pulse; the pulse is dropped before the next one so none merge.
  task automatic fw(input int k, input logic [7:0] v);
    @(posedge mclk_in);
    own_address_data_in <= v;
    buffer_data_in <= v;
    case (k)
      0: own_address_wr_in <= 1'b1;
      1: buffer_wr_in <= 1'b1;
      2: buffer_rd_in <= 1'b1;
      3: clock_release_set_in <= 1'b1;
      4: overflow_clr_in <= 1'b1;
      default: irq_clr_in <= 1'b1;
    endcase
    @(posedge mclk_in);
    {own_address_wr_in, buffer_wr_in, buffer_rd_in} <= 3'h0;
    {clock_release_set_in, overflow_clr_in, irq_clr_in} <= 3'h0;
    repeat (2) @(posedge mclk_in);
  endtask : fw
  // A byte on the wire, then time for the synchronisers to land the flags.
  task automatic xb(input logic [7:0] tx, input logic ack_bit);
    u_i2c_master_model.xfer_byte(tx, ack_bit, rx, acked);
    if (u_i2c_master_model.stuck != 0) begin
      err_count++;
      end_of_test();
    end
    repeat (6) @(posedge mclk_in);
  endtask : xb
  initial begin
    repeat (100000) @(posedge mclk_in);
    err_count++;
    end_of_test();
  end
  initial begin
    {arst_n_in, own_address_wr_in, buffer_wr_in, buffer_rd_in} = 4'h0;
    {clock_release_set_in, overflow_clr_in, irq_clr_in, stretch_enable_in} = 4'h0;
    {clk_en_in, port_enable_in} = 2'h3;
    port_mode_in = MODE_SLAVE_7;
    own_address_data_in = 8'h00;
    buffer_data_in = 8'h00;
    seed = 32'h1B2C;
    repeat (16) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    check("own_address", own_address_out, OWN_ADDRESS_RST);
    check("release", clock_release_out, CLOCK_RELEASE_RST);
    check("buffer", holding_buffer_out, 8'h00);
    check("flags", {buffer_full_out, receive_overflow_out, port_interrupt_out}, 8'h00);
    // Both 7-bit modes: accepted address, refused byte into a full buffer, miss.
    for (int m = 0; m < 2; m++) begin
      port_mode_in <= (m == 1) ? MODE_SLAVE_7_SP : MODE_SLAVE_7;
      seed = lfsr(lfsr(seed));
      a = seed[6:0];
      fw(0, addr7(a, 1'b0));
      u_i2c_master_model.start_cond();
      xb(addr7(a, 1'b0), 1'b1);
      check("addr_ack", acked, 1'b1);
      check("full", buffer_full_out, 1'b1);
      check("buffer", holding_buffer_out, addr7(a, 1'b0));
      check("irq", port_interrupt_out, 1'b1);
      check("dir", direction_out, 1'b0);
      check("no_stretch", scl_oe_out, 1'b0);
      fw(5, 8'h00);
      check("irq_clr", port_interrupt_out, 1'b0);
      xb(seed[15:8], 1'b1);
      check("ovf_ack", acked, 1'b0);
      check("ovf", receive_overflow_out, 1'b1);
      check("kept", holding_buffer_out, addr7(a, 1'b0));
      u_i2c_master_model.stop_cond();
      fw(4, 8'h00);
      check("ovf_clr", receive_overflow_out, 1'b0);
      fw(2, 8'h00);
      check("rd_clr", buffer_full_out, 1'b0);
      u_i2c_master_model.start_cond();
      xb(addr7(a ^ 7'h01, 1'b0), 1'b1);
      check("miss_ack", acked, 1'b0);
      check("miss_full", buffer_full_out, 1'b0);
      u_i2c_master_model.stop_cond();
    end
    // Receive with stretching: a full buffer at the ninth fall holds the clock.
    stretch_enable_in <= 1'b1;
    u_i2c_master_model.start_cond();
    xb(addr7(a, 1'b0), 1'b1);
    fw(2, 8'h00);
    fw(5, 8'h00);
    d = seed[23:16];
    xb(d, 1'b1);
    check("rx_ack", acked, 1'b1);
    check("rx_data", holding_buffer_out, d);
    check("auto_clr", clock_release_out, 1'b0);
    repeat (30) @(posedge mclk_in);
    check("held", scl_oe_out, 1'b1);
    fw(3, 8'h00);
    check("set_full", clock_release_out, 1'b1);
    fw(2, 8'h00);
    check("freed", scl_oe_out, 1'b0);
    u_i2c_master_model.stop_cond();
    // Slave transmit stretches after the address even with stretching off.
    stretch_enable_in <= 1'b0;
    u_i2c_master_model.start_cond();
    xb(addr7(a, 1'b1), 1'b1);
    check("rd_ack", acked, 1'b1);
    check("rd_dir", direction_out, 1'b1);
    check("rd_hold", clock_release_out, 1'b0);
    check("rd_scl", scl_oe_out, 1'b1);
    fw(2, 8'h00);
    fw(5, 8'h00);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      fw(1, seed[7:0]);
      fw(3, 8'h00);
      xb(8'hFF, k == 1);
      check("tx_data", rx, seed[7:0]);
      if (k == 0) begin
        check("tx_irq", port_interrupt_out, 1'b1);
        check("tx_hold", clock_release_out, 1'b0);
        fw(5, 8'h00);
      end else begin
        check("nack_dir", direction_out, 1'b0);
      end
    end
    u_i2c_master_model.stop_cond();
    // Ten-bit write of both address bytes, then a repeated start for reading.
    port_mode_in <= MODE_SLAVE_10;
    stretch_enable_in <= 1'b1;
    seed = lfsr(seed);
    hi = ten_hi(seed[9:8], 1'b0);
    fw(0, hi);
    u_i2c_master_model.start_cond();
    xb(hi, 1'b1);
    check("hi_ack", acked, 1'b1);
    check("hi_ua", address_update_out, 1'b1);
    check("hi_full", buffer_full_out, 1'b1);
    check("hi_scl", scl_oe_out, 1'b1);
    check("hi_rel", clock_release_out, 1'b1);
    fw(0, seed[7:0]);
    check("hi_ua_clr", address_update_out, 1'b0);
    check("hi_free", scl_oe_out, 1'b0);
    fw(2, 8'h00);
    fw(5, 8'h00);
    xb(seed[7:0], 1'b1);
    check("lo_ack", acked, 1'b1);
    check("lo_ua", address_update_out, 1'b1);
    check("lo_buf", holding_buffer_out, seed[7:0]);
    check("lo_dir", direction_out, 1'b0);
    fw(0, hi);
    check("lo_ua_clr", address_update_out, 1'b0);
    fw(2, 8'h00);
    fw(5, 8'h00);
    u_i2c_master_model.start_cond();
    xb(ten_hi(seed[9:8], 1'b1), 1'b1);
    check("rs_ack", acked, 1'b1);
    check("rs_ua", address_update_out, 1'b0);
    check("rs_full", buffer_full_out, 1'b1);
    check("rs_dir", direction_out, 1'b1);
    fw(2, 8'h00);
    check("rs_rd", buffer_full_out, 1'b0);
    fw(1, seed[31:24]);
    fw(3, 8'h00);
    xb(8'hFF, 1'b1);
    check("ten_tx", rx, seed[31:24]);
    u_i2c_master_model.stop_cond();
    // A low clock enable freezes the core, so the flag clear is lost.
    clk_en_in <= 1'b0;
    fw(5, 8'h00);
    check("frozen_irq", port_interrupt_out, 1'b1);
    clk_en_in <= 1'b1;
    fw(5, 8'h00);
    check("thawed_irq", port_interrupt_out, 1'b0);
    end_of_test();
  end
endmodule : i2c_slave_addr_stretch_bench
